// *** logic/lcc_regs.svh ***
// register offsets, field positions, reset values of the ldo and charger control block
`ifndef LCC_REGS_SVH
`define LCC_REGS_SVH
`define LCC_ADDR_LDO      8'h00
`define LCC_ADDR_CHG      8'h04
`define LCC_ADDR_STATUS   8'h08
`define LCC_ADDR_DEC_AB   8'h0c
`define LCC_ADDR_DEC_C    8'h10
`define LCC_LDO_A_SP      1:0
`define LCC_LDO_B_SP      4:2
`define LCC_LDO_C_SP      5
`define LCC_LDO_C_PASS    6
`define LCC_LDO_C_EN      7
`define LCC_LDO_A_LP      8
`define LCC_LDO_B_LP      9
`define LCC_CHG_VOLT      2:0
`define LCC_CHG_CURR      6:3
`define LCC_CHG_TRICKLE   7
`define LCC_CHG_THERM_DIS 8
`define LCC_CHG_FET_OVR   9
`define LCC_CHG_FET_LVL   10
`define LCC_CHG_REVERSE   11
`define LCC_CHG_POWER_LIMIT_SETTING      13:12
`define LCC_CHG_POWER_LIMIT_SETTING_DIS  14
`define LCC_CHG_LED_EN    15
`define LCC_CHG_RESTART   16
`define LCC_CHG_AUTONOMY  17
`define LCC_CHG_SA_OVR    18
`define LCC_CHG_CYCL_DIS  19
`define LCC_ST_SC_FLAG    1
`define LCC_LDO_RST       10'h000
`define LCC_CHG_RST       20'h00003
`define LCC_SA_VOLT       3'h3
`define LCC_SA_CURR       4'h6
`define LCC_CURR_OFF      4'h0
`define LCC_CURR_FULL     4'hf
`endif

// *** logic/lcc_pkg.sv ***
// types of the ldo and charger control block
package lcc_pkg;
  typedef enum logic [2:0] {
    LCC_SEL_LDO    = 3'b000,
    LCC_SEL_CHG    = 3'b001,
    LCC_SEL_STATUS = 3'b010,
    LCC_SEL_DEC_AB = 3'b011,
    LCC_SEL_DEC_C  = 3'b100,
    LCC_SEL_NONE   = 3'b111
  } lcc_sel_type;
  typedef enum logic [1:0] {
    LCC_RESP_OKAY   = 2'b00,
    LCC_RESP_SLVERR = 2'b10
  } lcc_resp_type;
endpackage

// *** logic/lcc_chg_if.sv ***
// control bits and results passed between the top and the charger control
`timescale 1ns/1ps
interface lcc_chg_if;
  logic [19:0] bits;
  logic        serial_path;
  logic        batt_charged;
  logic        overvoltage;
  logic        led_request;
  logic        iso_pin;
  logic        fet_a;
  logic        fet_b;
  logic        trickle;
  logic        led_out;
  logic [2:0]  eff_volt;
  logic [3:0]  eff_curr;
  logic [12:0] volt_mv;
  modport top (output bits, serial_path, batt_charged, overvoltage, led_request,
               input iso_pin, fet_a, fet_b, trickle, led_out, eff_volt, eff_curr, volt_mv);
  modport chg (input bits, serial_path, batt_charged, overvoltage, led_request,
               output iso_pin, fet_a, fet_b, trickle, led_out, eff_volt, eff_curr, volt_mv);
endinterface

// *** logic/lcc_ldo_decode.sv ***
// set-point decode of the three general purpose regulators, in millivolts
`timescale 1ns/1ps
module lcc_ldo_decode (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        nrst_in,
  // set-point fields
  input  wire logic [1:0]  a_sp_in,
  input  wire logic [2:0]  b_sp_in,
  input  wire logic        c_sp_in,
  // decoded values
  output logic      [12:0] a_mv_out,
  output logic      [12:0] b_mv_out,
  output logic      [12:0] c_mv_out
);
  function automatic logic [12:0] mv_a(input logic [1:0] sp);
    case (sp)
      2'h0: mv_a = 13'h04b0;
      2'h1: mv_a = 13'h05dc;
      2'h2: mv_a = 13'h0ad7;
      default: mv_a = 13'h0c4e;
    endcase
  endfunction
  function automatic logic [12:0] mv_b(input logic [2:0] sp);
    case (sp)
      3'h0: mv_b = 13'h04b0;
      3'h1: mv_b = 13'h05dc;
      3'h2: mv_b = 13'h0640;
      3'h3: mv_b = 13'h0708;
      3'h4: mv_b = 13'h0a8c;
      3'h5: mv_b = 13'h0af0;
      3'h6: mv_b = 13'h0bb8;
      default: mv_b = 13'h0c4e;
    endcase
  endfunction
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      a_mv_out <= 13'h04b0;
      b_mv_out <= 13'h04b0;
      c_mv_out <= 13'h0708;
    end
    else
    begin
      a_mv_out <= mv_a(a_sp_in);
      b_mv_out <= mv_b(b_sp_in);
      c_mv_out <= c_sp_in ? 13'h0b54 : 13'h0708;
    end
  end
endmodule

// *** logic/lcc_chg_ctrl.sv ***
// charge path fet, trickle and indicator control from the software bits
`timescale 1ns/1ps
`include "lcc_regs.svh"
module lcc_chg_ctrl (
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic nrst_in,
  // control bits and results
  lcc_chg_if.chg    cif
);
  logic       use_sw;
  logic       dead_batt;
  logic       iso_on_hw;
  logic [2:0] volt_d;
  logic [3:0] curr_d;
  always_comb
  begin
    use_sw    = cif.bits[`LCC_CHG_AUTONOMY] | cif.bits[`LCC_CHG_SA_OVR];
    volt_d    = use_sw ? cif.bits[`LCC_CHG_VOLT] : `LCC_SA_VOLT;
    curr_d    = use_sw ? cif.bits[`LCC_CHG_CURR] : `LCC_SA_CURR;
    dead_batt = cif.serial_path & ~cif.batt_charged;
    // full-on current opens the isolation fet; reverse mode closes it regardless
    iso_on_hw = cif.bits[`LCC_CHG_REVERSE] |
                (~dead_batt & (curr_d != `LCC_CURR_FULL));
  end
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cif.iso_pin  <= 1'b1;
      cif.fet_a    <= 1'b0;
      cif.fet_b    <= 1'b0;
      cif.trickle  <= 1'b0;
      cif.led_out  <= 1'b0;
      cif.eff_volt <= `LCC_SA_VOLT;
      cif.eff_curr <= `LCC_CURR_OFF;
    end
    else
    begin
      // pin high keeps the isolation fet off
      cif.iso_pin  <= cif.bits[`LCC_CHG_FET_OVR] ? ~cif.bits[`LCC_CHG_FET_LVL]
                                                 : ~iso_on_hw;
      cif.fet_a    <= ~cif.overvoltage &
                      (cif.bits[`LCC_CHG_REVERSE] | (curr_d != `LCC_CURR_OFF));
      cif.fet_b    <= ~cif.overvoltage &
                      (cif.bits[`LCC_CHG_REVERSE] | (curr_d != `LCC_CURR_OFF));
      cif.trickle  <= cif.bits[`LCC_CHG_TRICKLE] | dead_batt;
      cif.led_out  <= cif.bits[`LCC_CHG_LED_EN] & cif.led_request;
      cif.eff_volt <= volt_d;
      cif.eff_curr <= curr_d;
    end
  end
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      cif.volt_mv <= 13'h1068;
    else
    begin
      case (volt_d)
        3'h0: cif.volt_mv <= 13'h0ed8;
        3'h1: cif.volt_mv <= 13'h1004;
        3'h2: cif.volt_mv <= 13'h1036;
        3'h3: cif.volt_mv <= 13'h1068;
        3'h4: cif.volt_mv <= 13'h109a;
        3'h5: cif.volt_mv <= 13'h10cc;
        3'h6: cif.volt_mv <= 13'h1117;
        default: cif.volt_mv <= 13'h1162;
      endcase
    end
  end
endmodule

// *** logic/lcc_ctrl_top.sv ***
// ldo and charger control bits behind an axi4-lite slave
`timescale 1ns/1ps
`include "lcc_regs.svh"
module lcc_ctrl_top (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        nrst_in,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [7:0]  s_axi_awaddr_in,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  // axi4-lite write response
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  output logic      [1:0]  s_axi_bresp_out,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  input  wire logic [7:0]  s_axi_araddr_in,
  // axi4-lite read data
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic      [31:0] s_axi_rdata_out,
  output logic      [1:0]  s_axi_rresp_out,
  // asynchronous sense pins
  input  wire logic        short_circuit_in,
  input  wire logic        charger_overvoltage_in,
  input  wire logic        serial_path_in,
  input  wire logic        battery_charged_in,
  input  wire logic        charge_led_request_in,
  // general purpose regulators
  output logic      [1:0]  aux_ldo_a_setpoint_out,
  output logic      [2:0]  aux_ldo_b_setpoint_out,
  output logic             aux_ldo_c_setpoint_out,
  output logic             aux_ldo_c_pass_select_out,
  output logic             aux_ldo_c_enable_out,
  output logic             aux_ldo_a_lowpower_out,
  output logic             aux_ldo_b_lowpower_out,
  output logic             short_circuit_irq_out,
  // charger
  output logic             isolation_fet_pin_out,
  output logic             charge_pass_fet_a_out,
  output logic             charge_pass_fet_b_out,
  output logic             reverse_supply_enable_out,
  output logic      [1:0]  power_limit_setting_out,
  output logic             power_limit_disable_out,
  output logic             charge_indicator_output_out,
  output logic             charger_fsm_restart_out,
  output logic             charge_autonomy_select_out,
  output logic             resume_cycling_disable_out,
  output logic             trickle_source_enable_out,
  output logic             thermistor_check_disable_out,
  output logic      [2:0]  charge_voltage_field_out,
  output logic      [3:0]  charge_current_field_out
);
  localparam int NSYNC = 5;

  logic [9:0]              ldo_q;
  logic [19:0]             chg_q;
  logic                    sc_flag_q;
  logic                    sc_prev_q;
  logic                    irq_q;
  logic                    restart_q;
  logic                    aw_got_q;
  logic [7:0]              aw_addr_q;
  logic                    w_got_q;
  logic [31:0]             w_data_q;
  logic [3:0]              w_strb_q;
  logic                    bvalid_q;
  logic [1:0]              bresp_q;
  logic                    rvalid_q;
  logic [31:0]             rdata_q;
  logic [1:0]              rresp_q;
  logic [NSYNC-1:0]        sync1_q;
  logic [NSYNC-1:0]        sync2_q;
  logic [NSYNC-1:0]        pins;
  logic                    do_write;
  logic                    sc_edge;
  lcc_pkg::lcc_sel_type    wr_sel;
  lcc_pkg::lcc_sel_type    rd_sel;
  logic [31:0]             ldo_merged;
  logic [31:0]             chg_merged;
  logic [31:0]             rd_word;
  logic [12:0]             a_mv;
  logic [12:0]             b_mv;
  logic [12:0]             c_mv;

  lcc_chg_if cif ();

  // register select from a byte address; unaligned addresses are unmapped
  function automatic lcc_pkg::lcc_sel_type reg_sel(input logic [7:0] addr);
    if (addr == `LCC_ADDR_LDO)
      reg_sel = lcc_pkg::LCC_SEL_LDO;
    else if (addr == `LCC_ADDR_CHG)
      reg_sel = lcc_pkg::LCC_SEL_CHG;
    else if (addr == `LCC_ADDR_STATUS)
      reg_sel = lcc_pkg::LCC_SEL_STATUS;
    else if (addr == `LCC_ADDR_DEC_AB)
      reg_sel = lcc_pkg::LCC_SEL_DEC_AB;
    else if (addr == `LCC_ADDR_DEC_C)
      reg_sel = lcc_pkg::LCC_SEL_DEC_C;
    else
      reg_sel = lcc_pkg::LCC_SEL_NONE;
  endfunction

  // byte-lane merge of write data over the old word
  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[i*8 +: 8] = new_w[i*8 +: 8];
    end
    merge = r;
  endfunction

  // two-stage synchronisers for the sense pins
  assign pins = {charge_led_request_in, battery_charged_in, serial_path_in,
                 charger_overvoltage_in, short_circuit_in};
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++)
    begin : g_sync
      always_ff @(posedge sys_clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
        end
        else
        begin
          sync1_q[g] <= pins[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate

  // write channel: address and data taken in either order, one write at a time
  assign s_axi_awready_out = ~aw_got_q & ~bvalid_q;
  assign s_axi_wready_out  = ~w_got_q & ~bvalid_q;
  assign do_write          = aw_got_q & w_got_q & ~bvalid_q;
  assign wr_sel            = reg_sel(aw_addr_q);
  assign ldo_merged        = merge({22'h000000, ldo_q}, w_data_q, w_strb_q);
  assign chg_merged        = merge({12'h000, chg_q}, w_data_q, w_strb_q);

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      aw_got_q  <= 1'b0;
      aw_addr_q <= 8'h00;
    end
    else if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      aw_got_q  <= 1'b1;
      aw_addr_q <= s_axi_awaddr_in;
    end
    else if (do_write)
      aw_got_q  <= 1'b0;
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      w_got_q  <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end
    else if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      w_got_q  <= 1'b1;
      w_data_q <= s_axi_wdata_in;
      w_strb_q <= s_axi_wstrb_in;
    end
    else if (do_write)
      w_got_q  <= 1'b0;
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= lcc_pkg::LCC_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_sel == lcc_pkg::LCC_SEL_NONE) ? lcc_pkg::LCC_RESP_SLVERR
                                                     : lcc_pkg::LCC_RESP_OKAY;
    end
    else if (s_axi_bready_in)
      bvalid_q <= 1'b0;
  end

  // short circuit on ldo c, detected on the synchronised rising edge
  assign sc_edge = sync2_q[0] & ~sc_prev_q;

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      sc_prev_q <= 1'b0;
    else
      sc_prev_q <= sync2_q[0];
  end

  // regulator bits; ldo c enable resets low so the pass select can be set first
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      ldo_q <= `LCC_LDO_RST;
    else
    begin
      if (do_write && wr_sel == lcc_pkg::LCC_SEL_LDO)
        ldo_q <= ldo_merged[9:0];
      // the shutdown wins over a same-cycle enable write
      if (sc_edge)
        ldo_q[`LCC_LDO_C_EN] <= 1'b0;
    end
  end

  // charger bits; the restart bit is not stored and reads as zero
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      chg_q <= `LCC_CHG_RST;
    else if (do_write && wr_sel == lcc_pkg::LCC_SEL_CHG)
    begin
      chg_q <= chg_merged[19:0];
      chg_q[`LCC_CHG_RESTART] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      restart_q <= 1'b0;
    else
      restart_q <= do_write && wr_sel == lcc_pkg::LCC_SEL_CHG &&
                   chg_merged[`LCC_CHG_RESTART];
  end

  // sticky short-circuit flag, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sc_flag_q <= 1'b0;
      irq_q     <= 1'b0;
    end
    else
    begin
      irq_q <= sc_edge;
      if (sc_edge)
        sc_flag_q <= 1'b1;
      else if (do_write && wr_sel == lcc_pkg::LCC_SEL_STATUS && w_strb_q[0] &&
               w_data_q[`LCC_ST_SC_FLAG])
        sc_flag_q <= 1'b0;
    end
  end

  // read channel: one read at a time, data registered
  assign s_axi_arready_out = ~rvalid_q;
  assign rd_sel            = reg_sel(s_axi_araddr_in);

  always_comb
  begin
    rd_word = 32'h00000000;
    case (rd_sel)
      lcc_pkg::LCC_SEL_LDO:    rd_word = {22'h000000, ldo_q};
      lcc_pkg::LCC_SEL_CHG:    rd_word = {12'h000, chg_q};
      lcc_pkg::LCC_SEL_STATUS: rd_word = {24'h000000, sync2_q[3], sync2_q[2], sync2_q[1],
                                          cif.iso_pin, cif.fet_b, cif.fet_a, sc_flag_q,
                                          ldo_q[`LCC_LDO_C_EN]};
      lcc_pkg::LCC_SEL_DEC_AB: rd_word = {3'h0, b_mv, 3'h0, a_mv};
      lcc_pkg::LCC_SEL_DEC_C:  rd_word = {3'h0, cif.volt_mv, 3'h0, c_mv};
      default:                 rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= lcc_pkg::LCC_RESP_OKAY;
    end
    else if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= (rd_sel == lcc_pkg::LCC_SEL_NONE) ? lcc_pkg::LCC_RESP_SLVERR
                                                     : lcc_pkg::LCC_RESP_OKAY;
    end
    else if (s_axi_rready_in)
      rvalid_q <= 1'b0;
  end

  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out  = bresp_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out  = rdata_q;
  assign s_axi_rresp_out  = rresp_q;

  // set-point decode
  lcc_ldo_decode u_ldo_decode (
    .sys_clk_in (sys_clk_in),
    .nrst_in    (nrst_in),
    .a_sp_in    (ldo_q[`LCC_LDO_A_SP]),
    .b_sp_in    (ldo_q[`LCC_LDO_B_SP]),
    .c_sp_in    (ldo_q[`LCC_LDO_C_SP]),
    .a_mv_out   (a_mv),
    .b_mv_out   (b_mv),
    .c_mv_out   (c_mv)
  );

  // charge path control
  assign cif.bits         = chg_q;
  assign cif.overvoltage  = sync2_q[1];
  assign cif.serial_path  = sync2_q[2];
  assign cif.batt_charged = sync2_q[3];
  assign cif.led_request  = sync2_q[4];

  lcc_chg_ctrl u_chg_ctrl (
    .sys_clk_in (sys_clk_in),
    .nrst_in    (nrst_in),
    .cif        (cif)
  );

  // regulator outputs straight from the register bits; the irq from the registered short-circuit edge
  assign aux_ldo_a_setpoint_out    = ldo_q[`LCC_LDO_A_SP];
  assign aux_ldo_b_setpoint_out    = ldo_q[`LCC_LDO_B_SP];
  assign aux_ldo_c_setpoint_out    = ldo_q[`LCC_LDO_C_SP];
  assign aux_ldo_c_pass_select_out = ldo_q[`LCC_LDO_C_PASS];
  assign aux_ldo_c_enable_out      = ldo_q[`LCC_LDO_C_EN];
  assign aux_ldo_a_lowpower_out    = ldo_q[`LCC_LDO_A_LP];
  assign aux_ldo_b_lowpower_out    = ldo_q[`LCC_LDO_B_LP];
  assign short_circuit_irq_out     = irq_q;

  // charger outputs
  assign isolation_fet_pin_out        = cif.iso_pin;
  assign charge_pass_fet_a_out        = cif.fet_a;
  assign charge_pass_fet_b_out        = cif.fet_b;
  assign reverse_supply_enable_out    = chg_q[`LCC_CHG_REVERSE];
  assign power_limit_setting_out      = chg_q[`LCC_CHG_POWER_LIMIT_SETTING];
  assign power_limit_disable_out      = chg_q[`LCC_CHG_POWER_LIMIT_SETTING_DIS];
  assign charge_indicator_output_out  = cif.led_out;
  assign charger_fsm_restart_out      = restart_q;
  assign charge_autonomy_select_out   = chg_q[`LCC_CHG_AUTONOMY];
  assign resume_cycling_disable_out   = chg_q[`LCC_CHG_CYCL_DIS];
  assign trickle_source_enable_out    = cif.trickle;
  assign thermistor_check_disable_out = chg_q[`LCC_CHG_THERM_DIS];
  assign charge_voltage_field_out     = cif.eff_volt;
  assign charge_current_field_out     = cif.eff_curr;
endmodule

// *** test/lcc_ctrl_top_asserts.sv ***
// port assertions of the ldo and charger control top
`timescale 1ns/1ps
module lcc_ctrl_top_asserts (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // watched pins
  input wire logic short_circuit_irq_out,
  input wire logic aux_ldo_c_enable_out,
  input wire logic charger_overvoltage_in,
  input wire logic charge_pass_fet_a_out,
  input wire logic charge_pass_fet_b_out,
  input wire logic charger_fsm_restart_out,
  input wire logic reverse_supply_enable_out,
  input wire logic s_axi_bvalid_out,
  input wire logic serial_path_in,
  input wire logic battery_charged_in,
  input wire logic trickle_source_enable_out,
  input wire logic charge_led_request_in,
  input wire logic charge_indicator_output_out
);
  // pins pass a 2 flop sync, so level rules wait 4 samples
  default clocking dc @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  chk_irq_one_pulse: assert property (
    short_circuit_irq_out |=> !short_circuit_irq_out) else $error("irq pulse too long");
  chk_sc_ldo_off: assert property (
    short_circuit_irq_out |-> ##[0:2] !aux_ldo_c_enable_out) else $error("ldo c kept on");
  chk_ldo_c_sw_only: assert property (
    $rose(aux_ldo_c_enable_out) |-> s_axi_bvalid_out) else $error("ldo c on without write");
  chk_ov_fets_off: assert property (
    charger_overvoltage_in [*4] |-> !charge_pass_fet_a_out && !charge_pass_fet_b_out)
    else $error("pass fet on at overvoltage");
  chk_rev_fets_on: assert property (
    (reverse_supply_enable_out && !charger_overvoltage_in) [*4]
    |-> charge_pass_fet_a_out && charge_pass_fet_b_out) else $error("reverse fets off");
  chk_restart_pulse: assert property (
    charger_fsm_restart_out |=> !charger_fsm_restart_out) else $error("restart too long");
  chk_dead_trickle: assert property (
    (serial_path_in && !battery_charged_in) [*4] |-> trickle_source_enable_out)
    else $error("no trickle on dead battery");
  chk_led_idle_off: assert property (
    !charge_led_request_in [*4] |-> !charge_indicator_output_out) else $error("led on idle");
  cover property (short_circuit_irq_out);
  cover property (charger_fsm_restart_out);
  cover property (reverse_supply_enable_out && charge_pass_fet_a_out);
endmodule
bind lcc_ctrl_top lcc_ctrl_top_asserts chk_u (.*);

// *** test/lcc_ctrl_top_test.sv ***
// self-checking bench of the ldo and charger control top
`timescale 1ns/1ps
module lcc_ctrl_top_test;
  logic sys_clk_in = 1'b0;
  logic nrst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in;
  logic s_axi_rready_in, short_circuit_in, charger_overvoltage_in, serial_path_in;
  logic battery_charged_in, charge_led_request_in, s_axi_awready_out, s_axi_wready_out;
  logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, aux_ldo_c_setpoint_out;
  logic aux_ldo_c_pass_select_out, aux_ldo_c_enable_out, aux_ldo_a_lowpower_out;
  logic aux_ldo_b_lowpower_out, short_circuit_irq_out, isolation_fet_pin_out;
  logic charge_pass_fet_a_out, charge_pass_fet_b_out, reverse_supply_enable_out;
  logic power_limit_disable_out, charge_indicator_output_out, charger_fsm_restart_out;
  logic charge_autonomy_select_out, resume_cycling_disable_out, trickle_source_enable_out;
  logic thermistor_check_disable_out, iso, fet, dead;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, aux_ldo_a_setpoint_out, rs;
  logic [1:0] power_limit_setting_out;
  logic [2:0] aux_ldo_b_setpoint_out, charge_voltage_field_out, ev;
  logic [3:0] s_axi_wstrb_in, charge_current_field_out, ec, p;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rv, d, seed = 32'h5696;
  int mismatches = 0, checks = 0, pulses = 0, n;
  int mvq[$];
  int amv[4] = '{1200, 1500, 2775, 3150};
  int bmv[8] = '{1200, 1500, 1600, 1800, 2700, 2800, 3000, 3150};
  int vmv[8] = '{3800, 4100, 4150, 4200, 4250, 4300, 4375, 4450};
  lcc_ctrl_top dut_u (.*);
  always #2 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) if (charger_fsm_restart_out === 1'b1) pulses++;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // every handshake and irq wait goes through here so a hang ends the run
  task automatic tick(inout int k);
    @(posedge sys_clk_in);
    k++;
    if (k > 60)
    begin
      chk("wait", 32'h1, 32'h0);
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k = 0;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= v;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do
    begin
      tick(k);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end
    while (!s_axi_bvalid_out);
    rs = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic rd(input logic [7:0] a);
    int k = 0;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do
    begin
      tick(k);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end
    while (!s_axi_rvalid_out);
    rv = s_axi_rdata_out;
    rs = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  initial
  begin
    {nrst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in,
     s_axi_rready_in, short_circuit_in, charger_overvoltage_in, serial_path_in,
     battery_charged_in, charge_led_request_in, s_axi_awaddr_in, s_axi_araddr_in,
     s_axi_wdata_in} <= '0;
    s_axi_wstrb_in <= 4'hf;
    repeat (6) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(posedge sys_clk_in);
    rd(8'h00);
    chk("ldo reset", 32'h0, rv);
    rd(8'h04);
    chk("chg reset", 32'h3, rv);
    wr(8'h14, 32'hffffffff);
    chk("wr resp", 32'h2, 32'(rs));
    rd(8'h14);
    chk("rd resp", 32'h2, 32'(rs));
    for (int i = 0; i < 8; i++)
    begin
      d = (xs() & 32'h3c0) | (i & 3) | (i << 2) | ((i & 1) << 5);
      wr(8'h00, d);
      chk("ldo pins", d & 32'h3ff, {aux_ldo_b_lowpower_out, aux_ldo_a_lowpower_out,
          aux_ldo_c_enable_out, aux_ldo_c_pass_select_out, aux_ldo_c_setpoint_out,
          aux_ldo_b_setpoint_out, aux_ldo_a_setpoint_out});
      mvq.push_back((bmv[i] << 16) | amv[i & 3]);
      mvq.push_back((vmv[3] << 16) | ((i & 1) ? 2900 : 1800));
      rd(8'h0c);
      chk("ab mv", 32'(mvq.pop_front()), rv);
      rd(8'h10);
      chk("c mv", 32'(mvq.pop_front()), rv);
    end
    // restart bit kept out here: its pulse is counted on its own below
    for (int i = 0; i < 12; i++)
    begin
      d = xs() & 32'heffff;
      p = 4'(xs());
      {charger_overvoltage_in, serial_path_in, battery_charged_in, charge_led_request_in} <= p;
      wr(8'h04, d);
      rd(8'h04);
      chk("chg", d, rv);
      ev = (d[17] | d[18]) ? d[2:0] : 3'h3;
      ec = (d[17] | d[18]) ? d[6:3] : 4'h6;
      dead = p[2] & !p[1];
      iso = d[9] ? !d[10] : !(d[11] | (!dead & ec != 4'hf));
      fet = !p[3] & (d[11] | ec != 4'h0);
      chk("fet pins", {iso, fet, fet, d[11]}, {isolation_fet_pin_out, charge_pass_fet_a_out,
          charge_pass_fet_b_out, reverse_supply_enable_out});
      chk("chg bits", {d[14:12], d[17], d[19], d[8]}, {power_limit_disable_out,
          power_limit_setting_out, charge_autonomy_select_out, resume_cycling_disable_out,
          thermistor_check_disable_out});
      chk("trickle led", {d[7] | dead, d[15] & p[0]}, {trickle_source_enable_out,
          charge_indicator_output_out});
      chk("eff setting", {ev, ec},
          {charge_voltage_field_out, charge_current_field_out});
      rd(8'h10);
      chk("chg mv", 32'(vmv[ev]), rv >> 16);
    end
    wr(8'h04, 32'h10000);
    rd(8'h04);
    chk("restart", 32'h1, 32'(pulses) | (rv & 32'h10000));
    wr(8'h00, 32'h80);
    short_circuit_in <= 1'b1;
    n = 0;
    do
      tick(n);
    while (short_circuit_irq_out !== 1'b1);
    short_circuit_in <= 1'b0;
    rd(8'h00);
    chk("ldo c off", 32'h0, rv | 32'(aux_ldo_c_enable_out));
    rd(8'h08);
    chk("sc flag", 32'h2, rv & 32'h2);
    wr(8'h08, 32'h2);
    rd(8'h08);
    chk("sc clear", 32'h0, rv & 32'h2);
    // only byte lane 1 written: low-power bits set, ldo c enable left off
    s_axi_wstrb_in <= 4'h2;
    wr(8'h00, 32'hffffffff);
    rd(8'h00);
    chk("strobe", 32'h300, rv);
    end_of_test();
  end
endmodule
